// ### rpaf_pkg.sv
package rpaf_pkg;

	// ----------------------------------------
	// Register map and memory windows
	// ----------------------------------------
	localparam logic [9:0] BACKED_BASE    = 10'h100;
	localparam logic [9:0] CFGMEM_BASE    = 10'h300;
	localparam logic [9:0] PATCH_PTR_OFS  = 10'h128;
	localparam logic [9:0] ADDR_POS_OFS   = 10'h129;
	localparam logic [9:0] ADDR_LEN_OFS   = 10'h12A;
	localparam logic [9:0] STATUS_OFS     = 10'h140;
	localparam logic [9:0] APPLIED_OFS    = 10'h141;

	// ----------------------------------------
	// Field layout of the status register
	// ----------------------------------------
	localparam int STAT_BUSY_BIT     = 0;
	localparam int STAT_DONE_BIT     = 1;
	localparam int STAT_PTR_BAD_BIT  = 2;
	localparam int STAT_FILT_EN_BIT  = 3;

	// ----------------------------------------
	// Values and limits
	// ----------------------------------------
	localparam int         BACKED_DEPTH   = 64;
	localparam int         MAX_PAIRS      = 9;
	localparam logic [7:0] PTR_OFF        = 8'h00;
	localparam logic [7:0] PTR_MIN        = 8'h2A;
	localparam logic [7:0] PTR_MAX        = 8'h3D;
	localparam logic [7:0] LIST_END       = 8'h00;
	localparam logic [7:0] FILT_LIST_LO   = 8'h2B;
	localparam logic [7:0] BYTE_RST       = 8'h00;
	localparam logic [3:0] COUNT_RST      = 4'h0;

endpackage

// ### rpaf_patch_walk.sv
`timescale 1ns/1ns
`default_nettype none

module rpaf_patch_walk #(
	parameter int MAX_PAIRS = rpaf_pkg::MAX_PAIRS
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       start_i,
	input  wire logic [7:0] ptr_i,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i,
	output logic      [7:0] rd_loc_o,
	output logic            wr_en_o,
	output logic      [7:0] wr_addr_o,
	output logic      [7:0] wr_data_o,
	output logic            busy_o,
	output logic            done_o,
	output logic      [3:0] pairs_o
);

	// ----------------------------------------
	// Walk states
	// ----------------------------------------
	typedef enum logic [3:0] {
		W_IDLE = 4'b0001,
		W_ADDR = 4'b0010,
		W_DATA = 4'b0100,
		W_DONE = 4'b1000
	} rpaf_walk_e;

	rpaf_walk_e state_q, state_d;
	logic [7:0] loc_q, loc_d;
	logic [7:0] tgt_q, tgt_d;
	logic [3:0] pairs_q, pairs_d;
	logic       wr_q, wr_d;
	logic [7:0] wdat_q, wdat_d;

	always_comb
	begin
		state_d = state_q;
		loc_d   = loc_q;
		tgt_d   = tgt_q;
		pairs_d = pairs_q;
		wr_d    = 1'b0;
		wdat_d  = wdat_q;
		unique case (state_q)
			W_IDLE, W_DONE:
			begin
				if (start_i)
				begin
					pairs_d = rpaf_pkg::COUNT_RST;
					loc_d   = ptr_i;
					// No walk at all when the pointer is cleared
					state_d = (ptr_i == rpaf_pkg::PTR_OFF) ? W_DONE : W_ADDR;
				end
			end
			W_ADDR:
			begin
				// Zero target byte, cap on pairs or running off memory ends it
				if (!rd_valid_i || rd_data_i == rpaf_pkg::LIST_END
					|| pairs_q == 4'(MAX_PAIRS))
				begin
					state_d = W_DONE;
				end
				else
				begin
					tgt_d   = rd_data_i;
					loc_d   = loc_q + 8'h01;
					state_d = W_DATA;
				end
			end
			W_DATA:
			begin
				state_d = rd_valid_i ? W_ADDR : W_DONE;
				wr_d    = rd_valid_i;
				wdat_d  = rd_data_i;
				pairs_d = rd_valid_i ? pairs_q + 4'h1 : pairs_q;
				// Pairs strictly in ascending order
				loc_d   = loc_q + 8'h01;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= W_IDLE;
			loc_q   <= rpaf_pkg::BYTE_RST;
			tgt_q   <= rpaf_pkg::BYTE_RST;
			pairs_q <= rpaf_pkg::COUNT_RST;
			wr_q    <= 1'b0;
			wdat_q  <= rpaf_pkg::BYTE_RST;
		end
		else
		begin
			state_q <= state_d;
			loc_q   <= loc_d;
			tgt_q   <= tgt_d;
			pairs_q <= pairs_d;
			wr_q    <= wr_d;
			wdat_q  <= wdat_d;
		end
	end

	assign rd_loc_o  = loc_q;
	assign wr_en_o   = wr_q;
	assign wr_addr_o = tgt_q;
	assign wr_data_o = wdat_q;
	assign busy_o    = (state_q == W_ADDR) || (state_q == W_DATA) || wr_q;
	assign done_o    = (state_q == W_DONE) && !wr_q;
	assign pairs_o   = pairs_q;

endmodule

`default_nettype wire

// ### rpaf_cfg_top.sv
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module rpaf_cfg_top #(
	parameter int BACKED_DEPTH = rpaf_pkg::BACKED_DEPTH,
	parameter int MAX_PAIRS    = rpaf_pkg::MAX_PAIRS
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	input  wire logic [9:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       sleep_i,
	input  wire logic [7:0] cfg_raddr_i,
	output logic      [7:0] cfg_rdata_o,
	input  wire logic [7:0] flt_byte_i,
	output logic      [7:0] flt_match_o,
	output logic      [7:0] flt_mask_o,
	output logic      [7:0] second_len_o,
	output logic      [7:0] addr_pos_o,
	output logic      [7:0] addr_len_o,
	output logic            addr_filter_en_o,
	output logic            patch_busy_o,
	output logic            rx_ready_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Memory bytes 0x100 upward; pointer fields live inside this array
	logic [7:0] backed_q [BACKED_DEPTH];
	logic [7:0] cfgmem_q [256];

	logic [7:0] rdata_q, rdata_d;
	logic [7:0] cfg_rdata_q;
	logic [7:0] match_q, mask_q, sec_q;
	logic [7:0] pos_q, len_q;
	logic       filt_en_q;
	logic       sleep_q;
	logic       start_q, start_d;
	logic       ready_q, ready_d;
	logic       busy_q;
	logic       ptr_bad_q, ptr_bad_d;

	logic [7:0] walk_loc;
	logic       walk_wr;
	logic [7:0] walk_waddr;
	logic [7:0] walk_wdata;
	logic       walk_busy;
	logic       walk_done;
	logic [3:0] walk_pairs;
	logic       walk_valid;
	logic [7:0] walk_rdata;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Low byte of a memory location, as the pointer holds it
	function automatic logic in_bb(input logic [7:0] lo);
		in_bb = (32'(lo) < BACKED_DEPTH);
	endfunction

	function automatic logic [7:0] bb_at(input logic [7:0] lo, input logic [7:0] img [BACKED_DEPTH]);
		bb_at = in_bb(lo) ? img[lo[$clog2(BACKED_DEPTH)-1:0]] : 8'h00;
	endfunction

	function automatic logic is_bb(input logic [9:0] a);
		is_bb = (a[9:8] == rpaf_pkg::BACKED_BASE[9:8]) && in_bb(a[7:0]);
	endfunction

	logic [7:0] ptr_w;
	assign ptr_w = backed_q[rpaf_pkg::PATCH_PTR_OFS[$clog2(BACKED_DEPTH)-1:0]];

	// ----------------------------------------
	// Patch sequencer
	// ----------------------------------------
	// Pointer selects location 0x100 plus its value
	assign walk_valid = in_bb(walk_loc);
	assign walk_rdata = bb_at(walk_loc, backed_q);

	rpaf_patch_walk #(
		.MAX_PAIRS (MAX_PAIRS)
	) u_walk (
		.sys_clk_i  (sys_clk_i),
		.rstn_i     (rstn_i),
		.start_i    (start_q),
		.ptr_i      (ptr_w),
		.rd_data_i  (walk_rdata),
		.rd_valid_i (walk_valid),
		.rd_loc_o   (walk_loc),
		.wr_en_o    (walk_wr),
		.wr_addr_o  (walk_waddr),
		.wr_data_o  (walk_wdata),
		.busy_o     (walk_busy),
		.done_o     (walk_done),
		.pairs_o    (walk_pairs)
	);

	always_comb
	begin
		// Leaving sleep kicks off a fresh walk
		start_d = sleep_q && !sleep_i;
		// Held off on the waking edge too: the old walk still reads as done
		if (sleep_i || sleep_q || start_q || walk_busy)
		begin
			ready_d = 1'b0;
		end
		else
		begin
			ready_d = walk_done;
		end
		// Flags a pointer outside the window software must respect
		ptr_bad_d = (ptr_w != rpaf_pkg::PTR_OFF)
			&& (ptr_w < rpaf_pkg::PTR_MIN || ptr_w > rpaf_pkg::PTR_MAX);
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sleep_q   <= 1'b1;
			start_q   <= 1'b0;
			ready_q   <= 1'b0;
			busy_q    <= 1'b0;
			ptr_bad_q <= 1'b0;
		end
		else
		begin
			sleep_q   <= sleep_i;
			start_q   <= start_d;
			ready_q   <= ready_d;
			busy_q    <= walk_busy || start_d;
			ptr_bad_q <= ptr_bad_d;
		end
	end

	// ----------------------------------------
	// Backed memory, written over the bus
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (int i = 0; i < BACKED_DEPTH; i++)
			begin
				backed_q[i] <= rpaf_pkg::BYTE_RST;
			end
		end
		else if (wr_i && is_bb(addr_i))
		begin
			backed_q[addr_i[$clog2(BACKED_DEPTH)-1:0]] <= wdata_i;
		end
	end

	// ----------------------------------------
	// Modem configuration memory
	// ----------------------------------------
	// Whole array clears in one cycle; costly but matches the power loss
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (int i = 0; i < 256; i++)
			begin
				cfgmem_q[i] <= rpaf_pkg::BYTE_RST;
			end
		end
		else if (sleep_i && !sleep_q)
		begin
			for (int i = 0; i < 256; i++)
			begin
				cfgmem_q[i] <= rpaf_pkg::BYTE_RST;
			end
		end
		else if (walk_wr)
		begin
			// Target byte is the low half of a 0x3xx register
			cfgmem_q[walk_waddr] <= walk_wdata;
		end
		else if (wr_i && addr_i[9:8] == rpaf_pkg::CFGMEM_BASE[9:8])
		begin
			cfgmem_q[addr_i[7:0]] <= wdata_i;
		end
	end

	// ----------------------------------------
	// Address filter settings
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pos_q       <= rpaf_pkg::BYTE_RST;
			len_q       <= rpaf_pkg::BYTE_RST;
			filt_en_q   <= 1'b0;
			match_q     <= rpaf_pkg::BYTE_RST;
			mask_q      <= rpaf_pkg::BYTE_RST;
			sec_q       <= rpaf_pkg::BYTE_RST;
			cfg_rdata_q <= rpaf_pkg::BYTE_RST;
		end
		else
		begin
			pos_q       <= backed_q[rpaf_pkg::ADDR_POS_OFS[$clog2(BACKED_DEPTH)-1:0]];
			len_q       <= backed_q[rpaf_pkg::ADDR_LEN_OFS[$clog2(BACKED_DEPTH)-1:0]];
			filt_en_q   <= backed_q[rpaf_pkg::ADDR_LEN_OFS[$clog2(BACKED_DEPTH)-1:0]]
				!= rpaf_pkg::BYTE_RST;
			// Match at even, mask at odd step from the list start
			match_q     <= bb_at(rpaf_pkg::FILT_LIST_LO + {flt_byte_i[6:0], 1'b0}, backed_q);
			mask_q      <= bb_at(rpaf_pkg::FILT_LIST_LO + {flt_byte_i[6:0], 1'b1}, backed_q);
			// Zero here ends the list, else it sizes the second field
			sec_q       <= bb_at(rpaf_pkg::FILT_LIST_LO
				+ {backed_q[rpaf_pkg::ADDR_LEN_OFS[$clog2(BACKED_DEPTH)-1:0]][6:0], 1'b0}, backed_q);
			cfg_rdata_q <= cfgmem_q[cfg_raddr_i];
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_i)
		begin
			if (is_bb(addr_i))
			begin
				rdata_d = backed_q[addr_i[$clog2(BACKED_DEPTH)-1:0]];
			end
			else if (addr_i == rpaf_pkg::STATUS_OFS)
			begin
				rdata_d[rpaf_pkg::STAT_BUSY_BIT]    = busy_q;
				rdata_d[rpaf_pkg::STAT_DONE_BIT]    = ready_q;
				rdata_d[rpaf_pkg::STAT_PTR_BAD_BIT] = ptr_bad_q;
				rdata_d[rpaf_pkg::STAT_FILT_EN_BIT] = filt_en_q;
			end
			else if (addr_i == rpaf_pkg::APPLIED_OFS)
			begin
				rdata_d = {4'h0, walk_pairs};
			end
			else if (addr_i[9:8] == rpaf_pkg::CFGMEM_BASE[9:8])
			begin
				rdata_d = cfgmem_q[addr_i[7:0]];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rdata_q <= rpaf_pkg::BYTE_RST;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o          = rdata_q;
	assign cfg_rdata_o      = cfg_rdata_q;
	assign flt_match_o      = match_q;
	assign flt_mask_o       = mask_q;
	assign second_len_o     = sec_q;
	assign addr_pos_o       = pos_q;
	assign addr_len_o       = len_q;
	assign addr_filter_en_o = filt_en_q;
	assign patch_busy_o     = busy_q;
	assign rx_ready_o       = ready_q;

endmodule

`default_nettype wire

// ### rpaf_cfg_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rpaf_cfg_checker #(
	parameter int BACKED_DEPTH = rpaf_pkg::BACKED_DEPTH,
	parameter int MAX_PAIRS    = rpaf_pkg::MAX_PAIRS
) (
	input wire logic       sys_clk_i,
	input wire logic       rstn_i,
	input wire logic [9:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       sleep_i,
	input wire logic [7:0] cfg_raddr_i,
	input wire logic [7:0] cfg_rdata_o,
	input wire logic [7:0] flt_byte_i,
	input wire logic [7:0] flt_match_o,
	input wire logic [7:0] flt_mask_o,
	input wire logic [7:0] second_len_o,
	input wire logic [7:0] addr_pos_o,
	input wire logic [7:0] addr_len_o,
	input wire logic       addr_filter_en_o,
	input wire logic       patch_busy_o,
	input wire logic       rx_ready_o
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [7:0] pos_w_q;
	logic [7:0] pos_w_d;
	logic [5:0] wait_q;
	logic [5:0] wait_d;

	// Wait counter clears while asleep or ready, else wraps to zero only after 0x3F, far above the bound, so no wrap hides a hang
	always_comb
	begin
		pos_w_d = pos_w_q;
		if (wr_i && addr_i == rpaf_pkg::ADDR_POS_OFS)
			pos_w_d = wdata_i;
		wait_d = 6'h00;
		if (!sleep_i && !rx_ready_o && wait_q != 6'h3F)
			wait_d = wait_q + 6'h01;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pos_w_q <= 8'h00;
			wait_q  <= 6'h00;
		end
		else
		begin
			pos_w_q <= pos_w_d;
			wait_q  <= wait_d;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_ptr_wr_rd;
		wr_i && addr_i == rpaf_pkg::PATCH_PTR_OFS ##1 rd_i && addr_i == rpaf_pkg::PATCH_PTR_OFS;
	endsequence
	sequence s_len_wr;
		wr_i && addr_i == rpaf_pkg::ADDR_LEN_OFS;
	endsequence
	sequence s_sleep_entry;
		$rose(sleep_i) ##1 sleep_i[*2];
	endsequence

	a_ptr_read_back: assert property (s_ptr_wr_rd |=> rdata_o == $past(wdata_i, 2))
		else $error("pointer read back differs");
	a_pos_copy: assert property (wr_i && addr_i == rpaf_pkg::ADDR_POS_OFS |-> ##2 addr_pos_o == pos_w_q)
		else $error("position output not updated");
	a_filter_en: assert property (s_len_wr |-> ##2 addr_filter_en_o == ($past(wdata_i, 2) != 8'h00))
		else $error("filter enable disagrees with length");
	a_ready_in_time: assert property (wait_q <= 6'h1E)
		else $error("patch walk too long");
	a_ready_stays: assert property (rx_ready_o && !sleep_i |=> rx_ready_o)
		else $error("ready dropped while awake");
	a_sleep_no_ready: assert property (sleep_i |=> !rx_ready_o)
		else $error("ready while asleep");
	a_busy_not_ready: assert property (patch_busy_o |-> !rx_ready_o)
		else $error("ready during patch walk");
	a_sleep_clear: assert property (s_sleep_entry |-> cfg_rdata_o == 8'h00)
		else $error("config memory kept over sleep");
endmodule

bind rpaf_cfg_top rpaf_cfg_checker #(.BACKED_DEPTH(BACKED_DEPTH), .MAX_PAIRS(MAX_PAIRS)) rpaf_cfg_checker_i (
	.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .sleep_i(sleep_i), .cfg_raddr_i(cfg_raddr_i), .cfg_rdata_o(cfg_rdata_o),
	.flt_byte_i(flt_byte_i), .flt_match_o(flt_match_o), .flt_mask_o(flt_mask_o),
	.second_len_o(second_len_o), .addr_pos_o(addr_pos_o), .addr_len_o(addr_len_o),
	.addr_filter_en_o(addr_filter_en_o), .patch_busy_o(patch_busy_o), .rx_ready_o(rx_ready_o));
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       sleep = 1'b0;
	logic [7:0] mraddr = 8'h00;
	logic [7:0] fbyte = 8'h00;
	logic [7:0] rdata, mrdata, fmatch, fmask, slen, apos, alen;
	logic       fen, busy, ready;
	int         errors = 0;
	int         n_tests = 0;

	rpaf_cfg_top rpaf_cfg_top_i (
		.sys_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .sleep_i(sleep), .cfg_raddr_i(mraddr), .cfg_rdata_o(mrdata),
		.flt_byte_i(fbyte), .flt_match_o(fmatch), .flt_mask_o(fmask), .second_len_o(slen),
		.addr_pos_o(apos), .addr_len_o(alen), .addr_filter_en_o(fen), .patch_busy_o(busy),
		.rx_ready_o(ready));

	initial
	begin
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask

	task automatic bwr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic brd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	// Write then read with no idle cycle between the strobes
	task automatic bwrrd(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, d);
	endtask

	task automatic mchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		mraddr <= a;
		@(posedge clk);
		#1 chk(mrdata, e);
	endtask

	// Sleep long enough for the clear, then wake and wait for the walk
	task automatic wake();
		@(posedge clk);
		sleep <= 1'b1;
		repeat (3) @(posedge clk);
		sleep <= 1'b0;
		@(posedge clk);
		#1;
		chk({7'h00, busy}, 8'h01);
		for (int i = 0; i < 40 && ready !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk({7'h00, ready}, 8'h01);
	endtask

	task automatic complete_run();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_bus();
		brd(10'h128, 8'h00);
		bwr(10'h128, 8'h2B);
		brd(10'h128, 8'h2B);
		bwrrd(10'h128, 8'h2B);
		brd(10'h200, 8'h00);
	endtask

	task automatic t_patch();
		bwr(10'h12B, 8'h5E);
		bwr(10'h12C, 8'h46);
		bwr(10'h12D, 8'h5F);
		bwr(10'h12E, 8'h78);
		bwr(10'h12F, 8'h00);
		bwr(10'h130, 8'h60);
		bwr(10'h131, 8'h99);
		wake();
		mchk(8'h5E, 8'h46);
		mchk(8'h60, 8'h00);
		mchk(8'h5F, 8'h78);
		brd(10'h141, 8'h02);
		brd(10'h140, 8'h02);
	endtask

	task automatic t_nine();
		for (int i = 0; i < 10; i++)
		begin
			bwr(10'h12B + 10'(2 * i), 8'(i + 1));
			bwr(10'h12C + 10'(2 * i), 8'(8'hA1 + i));
		end
		bwr(10'h13F, 8'h00);
		wake();
		mchk(8'h01, 8'hA1);
		mchk(8'h0A, 8'h00);
		mchk(8'h09, 8'hA9);
		brd(10'h141, 8'h09);
	endtask

	task automatic t_off();
		bwr(10'h128, 8'h50);
		brd(10'h140, 8'h06);
		bwr(10'h128, 8'h00);
		wake();
		mchk(8'h01, 8'h00);
	endtask

	task automatic t_filter();
		bwr(10'h129, 8'h10);
		bwr(10'h12A, 8'h02);
		bwr(10'h12B, 8'h11);
		bwr(10'h12C, 8'hF0);
		bwr(10'h12D, 8'h22);
		bwr(10'h12E, 8'h0F);
		bwr(10'h12F, 8'h03);
		fbyte <= 8'h01;
		repeat (3) @(posedge clk);
		#1 chk(apos, 8'h10);
		chk(alen, 8'h02);
		chk({7'h00, fen}, 8'h01);
		chk(fmatch, 8'h22);
		chk(fmask, 8'h0F);
		chk(slen, 8'h03);
		bwr(10'h12A, 8'h00);
		repeat (3) @(posedge clk);
		#1 chk({7'h00, fen}, 8'h00);
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_bus();
		t_patch();
		t_nine();
		t_off();
		t_filter();
		complete_run();
	end
endmodule
`default_nettype wire
